// ---- src/led_pwm_phase_shift_cfg.sv ----
// phase-shift configuration registers and phase-shifted period starts
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - register 0x12 holds codes of channels 3,4,5 in nibbles, reset zero.
// - register 0x13 holds codes of channels 6,7,8 in nibbles, reset zero.
// - register 0x14 holds codes of channels 9,10,11 in nibbles, reset zero.
// - codes 0x0..0xB shift period start by code times 30 degrees.
// - codes 0xC, 0xD, 0xE, 0xF give zero shift like code zero.
// - one dimming period is PERIOD clock cycles, 4096 by default.
module led_pwm_phase_shift_cfg #(
  parameter int PERIOD = phase_shift_pkg::PERIOD_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire phase_shift_pkg::reg_req_t req,
  output logic [phase_shift_pkg::DATA_W-1:0] rdData_ff,
  output logic rdValid_ff,
  output logic [phase_shift_pkg::NUM_CH-1:0] periodStart_ff
);
  logic [phase_shift_pkg::DATA_W-1:0] regA_ff, regB_ff, regC_ff;
  logic [phase_shift_pkg::DATA_W-1:0] nxt_regA, nxt_regB, nxt_regC;
  logic [phase_shift_pkg::DATA_W-1:0] nxt_rdData;
  logic nxt_rdValid;
  logic [phase_shift_pkg::CNT_W-1:0] periodCnt_ff, nxt_periodCnt;
  logic [phase_shift_pkg::CODE_W*phase_shift_pkg::NUM_CH-1:0] codes;
  logic [phase_shift_pkg::NUM_CH-1:0] starts;

  // register writes, reserved bit dropped
  always_comb begin
    nxt_regA = regA_ff;
    nxt_regB = regB_ff;
    nxt_regC = regC_ff;
    if (req.wrEn) begin
      unique case (req.addr)
        phase_shift_pkg::ADDR_CH3_TO_CH5: nxt_regA = req.wrData & phase_shift_pkg::REG_MASK;
        phase_shift_pkg::ADDR_CH6_TO_CH8: nxt_regB = req.wrData & phase_shift_pkg::REG_MASK;
        phase_shift_pkg::ADDR_CH9_TO_CH11: nxt_regC = req.wrData & phase_shift_pkg::REG_MASK;
        default: ;
      endcase
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    nxt_rdValid = req.rdEn;
    nxt_rdData = rdData_ff;
    if (req.rdEn) begin
      unique case (req.addr)
        phase_shift_pkg::ADDR_CH3_TO_CH5: nxt_rdData = regA_ff;
        phase_shift_pkg::ADDR_CH6_TO_CH8: nxt_rdData = regB_ff;
        phase_shift_pkg::ADDR_CH9_TO_CH11: nxt_rdData = regC_ff;
        default: nxt_rdData = '0;
      endcase
    end
  end

  // free-running period counter, wraps after one dimming period
  always_comb begin
    if (periodCnt_ff == phase_shift_pkg::CNT_W'(PERIOD - 1)) begin
      nxt_periodCnt = '0;
    end else begin
      nxt_periodCnt = periodCnt_ff + 1'b1;
    end
  end

  // register stage for configuration, read port and counter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regA_ff <= phase_shift_pkg::REG_RESET;
      regB_ff <= phase_shift_pkg::REG_RESET;
      regC_ff <= phase_shift_pkg::REG_RESET;
      rdData_ff <= '0;
      rdValid_ff <= 1'b0;
      periodCnt_ff <= '0;
    end else if (ce) begin
      regA_ff <= nxt_regA;
      regB_ff <= nxt_regB;
      regC_ff <= nxt_regC;
      rdData_ff <= nxt_rdData;
      rdValid_ff <= nxt_rdValid;
      periodCnt_ff <= nxt_periodCnt;
    end
  end

  // channel codes in order 3..11, low nibble first
  assign codes = {regC_ff[11:0], regB_ff[11:0], regA_ff[11:0]};

  // one start generator per channel
  for (genvar i = 0; i < phase_shift_pkg::NUM_CH; i++) begin : g_ch
    phase_start_gen #(.PERIOD(PERIOD)) u_gen (
      .mclk(mclk),
      .rst_b(rst_b),
      .ce(ce),
      .code(codes[i*phase_shift_pkg::CODE_W +: phase_shift_pkg::CODE_W]),
      .periodCnt(periodCnt_ff),
      .startPulse_ff(starts[i])
    );
  end

  assign periodStart_ff = starts;
endmodule
`default_nettype wire

// ---- src/phase_shift_pkg.sv ----
// constants, types and helpers shared by the phase-shift configuration block
package phase_shift_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 13;
  localparam int CODE_W = 4;
  localparam int NUM_CH = 9; // channels 3..11
  localparam int CNT_W = 12;
  localparam int PERIOD_CYCLES = 4096; // one dimming period in clock cycles
  localparam int PHASE_STEPS = 12; // 30 degree steps per period
  localparam logic [ADDR_W-1:0] ADDR_CH3_TO_CH5 = 8'h12;
  localparam logic [ADDR_W-1:0] ADDR_CH6_TO_CH8 = 8'h13;
  localparam logic [ADDR_W-1:0] ADDR_CH9_TO_CH11 = 8'h14;
  localparam logic [DATA_W-1:0] REG_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] REG_MASK = 13'h0fff; // bit 12 reserved
  localparam logic [CODE_W-1:0] CODE_MAX_VALID = 4'hb;
  localparam int FIELD_LO0 = 0;
  localparam int FIELD_LO1 = 4;
  localparam int FIELD_LO2 = 8;

  // register access request from the serial interface decoder
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } reg_req_t;

  typedef logic [CODE_W-1:0] phase_code_t;

  // delay in cycles for a phase code, rounded to nearest cycle
  function automatic logic [CNT_W-1:0] phaseDelay(input phase_code_t code, input int period);
    int prod;
    prod = 0;
    if (code <= CODE_MAX_VALID) begin
      prod = (int'(code) * period + PHASE_STEPS / 2) / PHASE_STEPS;
    end
    return CNT_W'(prod);
  endfunction
endpackage

// ---- src/phase_start_gen.sv ----
// per-channel period start pulse generator, shifted by the phase code
`timescale 1ns/1ps
`default_nettype none
module phase_start_gen #(
  parameter int PERIOD = phase_shift_pkg::PERIOD_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire phase_shift_pkg::phase_code_t code,
  input wire logic [phase_shift_pkg::CNT_W-1:0] periodCnt,
  output logic startPulse_ff
);
  logic nxt_startPulse;
  logic [phase_shift_pkg::CNT_W-1:0] delay;

  // start fires when the shared counter reaches this channel's offset
  always_comb begin
    delay = phase_shift_pkg::phaseDelay(code, PERIOD);
    nxt_startPulse = (periodCnt == delay);
  end

  // registered pulse
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      startPulse_ff <= 1'b0;
    end else if (ce) begin
      startPulse_ff <= nxt_startPulse;
    end
  end
endmodule
`default_nettype wire

// ---- tb/led_pwm_phase_shift_cfg_checker.sv ----
// assertion checker for the phase-shift configuration block
`timescale 1ns/1ps
`default_nettype none
module led_pwm_phase_shift_cfg_checker #(parameter int PERIOD = 12) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire phase_shift_pkg::reg_req_t req,
  input wire logic [12:0] rdData_ff,
  input wire logic rdValid_ff,
  input wire logic [8:0] periodStart_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // write to a mapped register, then a read of the same place
  sequence wrMap;
    ce && req.wrEn && req.addr inside {8'h12, 8'h13, 8'h14};
  endsequence
  sequence rdSame;
    ce && req.rdEn && !req.wrEn && req.addr == $past(req.addr);
  endsequence
  rd_pulse_a: assert property (ce && req.rdEn |=> rdValid_ff) else $error("no read valid");
  no_rd_a: assert property (ce && !req.rdEn |=> !rdValid_ff) else $error("stray valid");
  rd_back_a: assert property (wrMap ##1 rdSame |=> rdData_ff == ($past(req.wrData, 2) & 13'h0fff))
    else $error("read back differs");
  bit12_zero_a: assert property (rdValid_ff |-> !rdData_ff[12]) else $error("bit 12 set");
  unmapped_zero_a: assert property (ce && req.rdEn && !(req.addr inside {8'h12, 8'h13, 8'h14})
    |=> rdData_ff == 13'h0000) else $error("unmapped read");
  data_hold_a: assert property (!rdValid_ff |-> $stable(rdData_ff)) else $error("data moved");
  freeze_a: assert property (!ce |=> $stable(periodStart_ff)) else $error("not frozen");
  pulse_one_a: assert property (ce && periodStart_ff[0] |=> !periodStart_ff[0])
    else $error("long pulse");
endmodule
bind led_pwm_phase_shift_cfg led_pwm_phase_shift_cfg_checker #(.PERIOD(PERIOD)) i_chk (
  .mclk(mclk), .rst_b(rst_b), .ce(ce), .req(req), .rdData_ff(rdData_ff),
  .rdValid_ff(rdValid_ff), .periodStart_ff(periodStart_ff));
`default_nettype wire

// ---- tb/led_pwm_phase_shift_cfg_tb.sv ----
// testbench for the phase-shift configuration block
`timescale 1ns/1ps
`default_nettype none
module led_pwm_phase_shift_cfg_tb;
  logic mclk = 0, rst_b, ce, rdValid_ff;
  phase_shift_pkg::reg_req_t req;
  logic [12:0] rdData_ff;
  logic [8:0] periodStart_ff;
  int failCount = 0, nTests = 0, k, i, pos[9];
  int offs[9] = '{0, 1, 11, 0, 0, 0, 5, 6, 7};
  led_pwm_phase_shift_cfg #(.PERIOD(12)) i_led_pwm_phase_shift_cfg (.mclk(mclk), .rst_b(rst_b),
    .ce(ce), .req(req), .rdData_ff(rdData_ff), .rdValid_ff(rdValid_ff),
    .periodStart_ff(periodStart_ff));
  always #4 mclk = ~mclk;
  task chk(input string n, input logic [12:0] s, input logic [12:0] e);
    nTests++;
    if (s !== e) begin
      failCount++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // one access, called at a falling edge; a read is checked one cycle on
  task op(input logic w, input logic [7:0] a, input logic [12:0] d, input logic [12:0] e);
    req = '{w, !w, a, d};
    @(negedge mclk);
    if (!w) begin
      chk("valid", {12'h000, rdValid_ff}, 13'h0001);
      chk("data", rdData_ff, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #20000;
    failCount++;
    wrap_up;
  end
  initial begin
    rst_b = 0;
    ce = 1;
    req = '0;
    repeat (5) @(negedge mclk);
    rst_b = 1;
    op(0, 8'h12, 0, 0);
    op(0, 8'h13, 0, 0);
    op(0, 8'h14, 0, 0);
    op(1, 8'h12, 13'h1b10, 0);
    op(0, 8'h12, 0, 13'h0b10);
    op(1, 8'h13, 13'h0edc, 0);
    op(0, 8'h13, 0, 13'h0edc);
    op(1, 8'h14, 13'h0765, 0);
    op(0, 8'h14, 0, 13'h0765);
    op(0, 8'h15, 0, 0);
    ce = 0;
    op(1, 8'h14, 13'h0aaa, 0);
    ce = 1;
    op(0, 8'h14, 0, 13'h0765);
    req = '0;
    // position of each start pulse within one period, from channel 3's start
    for (i = 0; i < 9; i++) pos[i] = -1;
    for (k = 0; k < 30 && periodStart_ff[0] !== 1'b1; k++) @(negedge mclk);
    for (k = 0; k < 12; k++) begin
      for (i = 0; i < 9; i++) if (periodStart_ff[i] === 1'b1) pos[i] = k;
      @(negedge mclk);
    end
    chk("period", {12'h000, periodStart_ff[0]}, 13'h0001);
    for (i = 0; i < 9; i++) chk("start", 13'(pos[i]), 13'(offs[i]));
    wrap_up;
  end
endmodule
`default_nettype wire
